// *** link_wake_regs.vh ***
// Constants for the link wake notifier: timing figures, square-wave period and power class limits.
// Assumes a 100 MHz core clock; included by the notifier design file by bare name.
`ifndef LINK_WAKE_REGS_VH
`define LINK_WAKE_REGS_VH

// Core clock period in ns
`define CLK_PERIOD_NS 10
// Power-up wake time in ns and its cycle count (rounded down, a longest time)
`define POWERUP_WAKE_NS 167000
`define POWERUP_WAKE_CYC (`POWERUP_WAKE_NS / `CLK_PERIOD_NS)
// Low time on power status before it is judged inactive, in ns, and in cycles (rounded up)
`define PS_RESET_NS 2600
`define PS_RESET_CYC ((`PS_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Half period of the wake square wave, in cycles
`define WAKE_HALF_CYC 16
// Highest power class that requests the power-up wake pulse
`define PCLASS_WAKE_MAX 3'h4
// Reset value of the wake output
`define WAKE_RST 1'h0

`endif

// *** power_status_filter.v ***
// Low-time filter for the link power status input.
// Assumes the input is already synchronised to mclk.
`timescale 1ns/100ps
`default_nettype none
module power_status_filter #(
	parameter LOW_CYC = 260
)
(
	input wire mclk,
	input wire srst,
	input wire status_sync,
	output reg status_active_r
);
	reg [31:0] low_cnt_r;

	// Count low cycles; declare inactive only after more than LOW_CYC of them
	always @(posedge mclk)
	begin
		if (srst)
		begin
			low_cnt_r <= 32'h0;
			status_active_r <= 1'b0;
		end
		else if (status_sync)
		begin
			low_cnt_r <= 32'h0;
			status_active_r <= 1'b1;
		end
		else if (low_cnt_r > LOW_CYC)
			status_active_r <= 1'b0;
		else
			low_cnt_r <= low_cnt_r + 32'h1;
	end
endmodule
`default_nettype wire

// *** link_wake_notifier.v ***
// Wake notification toward the link-layer controller.
// Assumes pins (power status, straps) are asynchronous; packet, interrupt, bus reset and
// control bit arrive as mclk-domain signals from the physical-layer logic.
`include "link_wake_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module link_wake_notifier #(
	parameter POWERUP_CYC = `POWERUP_WAKE_CYC,
	parameter HALF_CYC = `WAKE_HALF_CYC,
	parameter PS_LOW_CYC = `PS_RESET_CYC
)
(
	input wire mclk,
	input wire srst,
	input wire link_power_status_in,
	input wire link_control_bit,
	input wire power_class_strap_bit0,
	input wire power_class_strap_bit1,
	input wire power_class_strap_bit2,
	input wire link_on_packet,
	input wire phy_interrupt,
	input wire interrupt_wake_enable,
	input wire bus_reset,
	output reg link_wake_out,
	output reg link_active_r,
	output reg [2:0] power_class_r
);
	localparam ST_IDLE = 3'h1;
	localparam ST_WAKE = 3'h2;
	localparam ST_POWERUP = 3'h4;

	reg ps_meta_r;
	reg ps_sync_r;
	reg [2:0] pc_meta_r;
	reg [2:0] pc_sync_r;
	reg [1:0] strap_wait_r;
	reg strap_taken_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [31:0] pu_cnt_r;
	reg [15:0] half_cnt_r;
	reg wave_r;
	reg int_pending_r;
	wire ps_active;
	wire link_active;
	wire wake_event;
	wire half_done;
	wire [2:0] strap_pins;
	wire strap_ready;

	// Two-stage synchroniser for the power status pin
	always @(posedge mclk)
	begin
		if (srst)
		begin
			ps_meta_r <= 1'b0;
			ps_sync_r <= 1'b0;
		end
		else
		begin
			ps_meta_r <= link_power_status_in;
			ps_sync_r <= ps_meta_r;
		end
	end

	// Strap pins gathered as one three-bit class value
	assign strap_pins = {power_class_strap_bit2, power_class_strap_bit1, power_class_strap_bit0};

	// Two-stage synchroniser per strap bit; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_strap_sync
			always @(posedge mclk)
			begin
				if (srst)
				begin
					pc_meta_r[gi] <= 1'b0;
					pc_sync_r[gi] <= 1'b0;
				end
				else
				begin
					pc_meta_r[gi] <= strap_pins[gi];
					pc_sync_r[gi] <= pc_meta_r[gi];
				end
			end
		end
	endgenerate

	// Settle count: the second stage holds the straps two edges after release
	always @(posedge mclk)
	begin
		if (srst)
			strap_wait_r <= 2'h0;
		else if (strap_wait_r != 2'h3)
			strap_wait_r <= strap_wait_r + 2'h1;
	end

	// Straps are valid in the second stage from this count on
	assign strap_ready = (strap_wait_r == 2'h2);

	power_status_filter #(
		.LOW_CYC(PS_LOW_CYC)
	)
	u_ps_filter (
		.mclk(mclk),
		.srst(srst),
		.status_sync(ps_sync_r),
		.status_active_r(ps_active)
	);

	// Link activity and wake-up events
	assign link_active = ps_active & link_control_bit;
	assign wake_event = link_on_packet | (phy_interrupt & interrupt_wake_enable);
	assign half_done = (half_cnt_r >= HALF_CYC[15:0] - 16'h1);

	// Strap capture once after reset release, after synchroniser settles
	always @(posedge mclk)
	begin
		if (srst)
		begin
			strap_taken_r <= 1'b0;
			power_class_r <= 3'h0;
		end
		else if (!strap_taken_r && strap_ready)
		begin
			strap_taken_r <= 1'b1;
			power_class_r <= pc_sync_r;
		end
	end

	// Interrupt condition held while link inactive; set wins over clear
	always @(posedge mclk)
	begin
		if (srst)
			int_pending_r <= 1'b0;
		else if (phy_interrupt & interrupt_wake_enable)
			int_pending_r <= 1'b1;
		else if (link_active)
			int_pending_r <= 1'b0;
	end

	// Next state
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (!strap_taken_r && strap_ready && pc_sync_r <= `PCLASS_WAKE_MAX && !link_active)
					state_nxt = ST_POWERUP;
				else if (!link_active && wake_event)
					state_nxt = ST_WAKE;
			end
			ST_WAKE:
			begin
				if (link_active)
					state_nxt = ST_IDLE;
				else if (bus_reset && !int_pending_r && !wake_event)
					state_nxt = ST_IDLE;
			end
			ST_POWERUP:
			begin
				if (link_active || pu_cnt_r >= POWERUP_CYC - 1)
					state_nxt = ST_IDLE;
				else if (bus_reset && !int_pending_r)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Registered view of link activity
	always @(posedge mclk)
	begin
		if (srst)
			link_active_r <= 1'b0;
		else
			link_active_r <= link_active;
	end

	// Power-up wake timer, counts only while in the power-up state
	always @(posedge mclk)
	begin
		if (srst)
			pu_cnt_r <= 32'h0;
		else if (state_r == ST_POWERUP)
			pu_cnt_r <= pu_cnt_r + 32'h1;
		else
			pu_cnt_r <= 32'h0;
	end

	// State and square wave
	always @(posedge mclk)
	begin
		if (srst)
		begin
			state_r <= ST_IDLE;
			half_cnt_r <= 16'h0;
			wave_r <= 1'b0;
			link_wake_out <= `WAKE_RST;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_nxt == ST_IDLE)
			begin
				half_cnt_r <= 16'h0;
				wave_r <= 1'b0;
				link_wake_out <= 1'b0;
			end
			else if (state_r == ST_IDLE)
			begin
				half_cnt_r <= 16'h0;
				wave_r <= 1'b1;
				link_wake_out <= 1'b1;
			end
			else if (half_done)
			begin
				half_cnt_r <= 16'h0;
				wave_r <= ~wave_r;
				link_wake_out <= ~wave_r;
			end
			else
			begin
				half_cnt_r <= half_cnt_r + 16'h1;
				link_wake_out <= wave_r;
			end
		end
	end
endmodule
`default_nettype wire

// *** link_wake_notifier_sva.sv ***
// Port checks for the wake notifier.
// Bound onto link_wake_notifier; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module link_wake_notifier_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic link_control_bit,
	input wire logic link_on_packet,
	input wire logic phy_interrupt,
	input wire logic interrupt_wake_enable,
	input wire logic bus_reset,
	input wire logic link_wake_out,
	input wire logic link_active_r,
	input wire logic [2:0] power_class_r
);
	wire w = link_wake_out;
	wire a = link_active_r;
	wire qi = phy_interrupt && interrupt_wake_enable;
	wire ev = link_on_packet || qi;
	logic ip_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// Qualified interrupt stays pending until the link is active
	always @(posedge mclk)
		ip_r <= !srst && (qi || ip_r && !a);
	sequence s_calm;
		!(a || bus_reset) [*2];
	endsequence
	chk_event_wake: assert property (ev && !a && !w && !$past(w, 16) ##1 s_calm |=> w) else $error("no wake");
	chk_wave_rise: assert property ($rose(w) && !bus_reset ##1 s_calm |-> w) else $error("short high");
	chk_wave_moves: assert property (w |-> ##[1:16] !w) else $error("stuck high");
	chk_active_quiet: assert property (a [*2] |-> !w) else $error("wake while active");
	chk_active_calc: assert property (!link_control_bit |=> !a) else $error("active, no control");
	chk_powerup_wake: assert property ($fell(srst) ##6 power_class_r < 3'h5 && !a |-> ##[0:8] w) else $error("no wake");
	chk_reset_clear: assert property (bus_reset && !ip_r && !ev |-> ##2 !w) else $error("wake kept");
	chk_pending_keep: assert property (bus_reset && ip_r && !a |-> ##[1:34] (w || a)) else $error("wake lost");
endmodule
bind link_wake_notifier link_wake_notifier_sva link_wake_notifier_sva_inst (.mclk, .srst, .link_control_bit,
	.link_on_packet, .phy_interrupt, .interrupt_wake_enable, .bus_reset, .link_wake_out, .link_active_r,
	.power_class_r);
`default_nettype wire

// *** link_partner.sv ***
// Link controller model: powers up on the wake wave once allowed.
// The bench holds fast low to keep it from answering and raises sleep to power down.
`timescale 1ns/100ps
`default_nettype none
module link_partner (
	input wire logic mclk,
	input wire logic wake,
	input wire logic sleep,
	input wire logic fast,
	output logic ps
);
	initial ps = 1'h0;
	// Power status set on the wake wave while fast is high and then held, dropped at once on sleep
	always @(posedge mclk)
	begin
		#2;
		ps = !sleep && (ps || wake && fast);
	end
endmodule
`default_nettype wire

// *** tb_link_wake_notifier.sv ***
// Bench: wake scenarios against the link partner model.
// The checker binds itself onto the design.
`timescale 1ns/100ps
`default_nettype none
`define ck(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: output differs", $time); end end
module tb_link_wake_notifier;
	logic mclk = 1'h0, srst = 1'h1, ctl = 1'h1, pkt = 1'h0, irq = 1'h0;
	logic ien = 1'h0, brst = 1'h0, slp = 1'h0, fast = 1'h0;
	logic [2:0] pc = 3'h0;
	logic [31:0] lf = 32'hF2D6;
	wire ps, w, a;
	wire [2:0] pcr;
	int fails = 0, n_compared = 0;
	link_wake_notifier #(.POWERUP_CYC(56), .PS_LOW_CYC(8)) link_wake_notifier_inst (.mclk, .srst,
		.link_power_status_in(ps), .link_control_bit(ctl), .power_class_strap_bit0(pc[0]),
		.power_class_strap_bit1(pc[1]), .power_class_strap_bit2(pc[2]), .link_on_packet(pkt),
		.phy_interrupt(irq), .interrupt_wake_enable(ien), .bus_reset(brst), .link_wake_out(w),
		.link_active_r(a), .power_class_r(pcr));
	link_partner link_partner_inst (.mclk, .wake(w), .sleep(slp), .fast, .ps);
	// Free-running clock
	always #5 mclk = ~mclk;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(2);
	endtask
	task results;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Watchdog well past the run length
	initial
	begin
		#20000;
		fails++;
		results;
	end
	// Power-up with both class ranges, then wake, stop, bus reset and sleep
	initial
	begin
		for (int i = 0; i < 2; i++)
		begin
			lf = nx(lf);
			pc = {i[0], lf[1:0] | i[1:0]};
			srst = 1'h1;
			cyc(20);
			srst = 1'h0;
			cyc(8);
			`ck({pcr, w}, {pc, pc < 3'h5})
			cyc(60);
			`ck(w, 1'h0)
		end
		pulse(irq);
		`ck(w, 1'h0)
		pulse(pkt);
		`ck(w, 1'h1)
		cyc(16);
		`ck(w, 1'h0)
		fast = 1'h1;
		cyc(24);
		`ck({a, w}, 2'h2)
		ctl = 1'h0;
		cyc(2);
		pulse(pkt);
		`ck({a, w}, 2'h1)
		pulse(brst);
		`ck(w, 1'h0)
		ien = 1'h1;
		pulse(irq);
		pulse(brst);
		`ck(w, 1'h1)
		ctl = 1'h1;
		cyc(3);
		`ck(w, 1'h0)
		fast = 1'h0;
		slp = 1'h1;
		cyc(6);
		`ck(a, 1'h1)
		cyc(12);
		`ck(a, 1'h0)
		results;
	end
endmodule
`default_nettype wire
